// >>> verilog/rcc_defs.svh
// offsets, field positions, reset values and timing counts
`ifndef RCC_DEFS_SVH
`define RCC_DEFS_SVH
`define RCC_OFF_STATUS     32'h0000_000c
`define RCC_OFF_CFG        32'h0000_801c
`define RCC_OFF_CTRL       32'h0000_0040
`define RCC_OFF_EVENT      32'h0000_0044
`define RCC_OFF_CAUSE      32'h0000_0048
`define RCC_OFF_PC         32'h0000_004c
`define RCC_OFF_INTCTL     32'h0000_0050
`define RCC_OFF_DIR        32'h0000_0054
`define RCC_CFG_ADDR       14'h2007
`define RCC_TEST_LO        14'h2000
`define RCC_CFG_ERASED     14'h3fff
`define RCC_CP_LSB         4
`define RCC_POWER_UP_DELAY_ENABLE_N_BIT      3
`define RCC_WATCHDOG_ENABLE_BIT       2
`define RCC_PC_ZERO        13'h0000
`define RCC_PC_VECTOR      13'h0004
`define RCC_STATUS_POR     8'h18
`define RCC_INTCTL_POR     8'h00
`define RCC_DIR_ALL_IN     8'hff
`define RCC_TO_BIT         4
`define RCC_PD_BIT         3
`define RCC_GIE_BIT        7
`define RCC_CLK_MHZ        250
`define RCC_POWER_UP_DELAY_TIMER_MS        72
`define RCC_POWER_UP_DELAY_TIMER_CYC       (`RCC_POWER_UP_DELAY_TIMER_MS * 1000 * `RCC_CLK_MHZ)
`define RCC_OST_OSC_CYC    1024
`define RCC_FILT_NS        8
`define RCC_FILT_CYC       ((`RCC_FILT_NS * `RCC_CLK_MHZ) / 1000)
`endif

// >>> verilog/rcc_pkg.sv
// types for the reset and configuration controller
package rcc_pkg;
    typedef enum logic [1:0] {
        RCC_OSC_LP = 2'b00,
        RCC_OSC_XT = 2'b01,
        RCC_OSC_HS = 2'b10,
        RCC_OSC_RC = 2'b11
    } rcc_osc_e;
    typedef enum logic [2:0] {
        RCC_K_NONE, RCC_K_POR, RCC_K_PIN_RUN, RCC_K_PIN_SLEEP,
        RCC_K_WDT_RUN, RCC_K_WDT_WAKE, RCC_K_IRQ_WAKE
    } rcc_kind_e;
    typedef struct packed {
        logic [9:0] code_protect;
        logic       power_up_delay_enable_n;
        logic       watchdog_enable;
        logic       osc_select_hi;
        logic       osc_select_lo;
    } rcc_cfg_s;
    typedef struct packed {
        logic        htrans1;
        logic        hwrite;
        logic [31:0] haddr;
    } rcc_aphase_s;
endpackage : rcc_pkg

// >>> verilog/rcc_top.sv
// reset and configuration controller with ahb-lite register slave
// Summary of operation
// RULE1 - programmed config bit reads 0, erased reads 1; word lives at 2007h
// RULE2 - test/config space reachable only in programming mode
// RULE3 - config bit 3 low enables the power-up delay timer
// RULE4 - config bit 2 high enables the watchdog
// RULE5 - oscillator select: 11 rc, 10 hs, 01 xt, 00 lp
// RULE6 - watchdog disabled only by config bit, runs from own rc clock
// RULE7 - power-up delay holds reset for 72 ms after power-up only
// RULE8 - oscillator start-up timer holds reset until crystal is stable
// RULE9 - sleep ends on external reset, watchdog time-out or enabled irq
// RULE10 - five reset kinds are told apart
// RULE11 - external reset pin is filtered against short noise pulses
// RULE12 - undefined registers keep value through non-power-on resets
// RULE13 - defined registers reset on all resets but watchdog wake-up; irq wake-up here keeps them too
// RULE14 - true reset loads pc 000h; wake-ups continue at pc plus one
// RULE15 - irq wake-up with global enable loads pc with vector 0004h
// RULE16 - status reset value depends on reset kind
// RULE17 - timeout and powerdown flags record reset cause
// RULE18 - interrupt control resets to zero except flag bit; wake keeps it
// RULE19 - every reset sets all port direction bits to input; wake-ups here leave them unchanged
// RULE20 - crystal modes take a crystal or external clock on the pins
// RULE21 - hs mode recommended for resonators above 3.5 MHz
// RULE22 - after power-up delay count 1024 oscillator cycles
// RULE23 - start-up delay only in crystal modes, on power-on or wake-up
// RULE24 - bits 13..4 code protect: ones readable, zeros protected
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`include "rcc_defs.svh"
module rcc_top #(
    parameter int POWER_UP_DELAY_TIMER_CYC = `RCC_POWER_UP_DELAY_TIMER_CYC
) (
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RST_N,
    // ahb-lite slave
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    // device pins and events
    input  wire logic        EXTERNAL_RESET_PIN_N,
    input  wire logic        OSC_TICK,
    input  wire logic        WDT_RC_TICK,
    input  wire logic        PROG_MODE,
    input  wire logic        SLEEPING,
    input  wire logic        IRQ_WAKE,
    input  wire logic [7:0]  WAKE_FLAGS,
    input  wire logic [12:0] PC_IN,
    // reset outputs and config decodes
    output logic             CORE_RESET,
    output logic [2:0]       RESET_KIND,
    output logic [12:0]      PC_LOAD,
    output logic             PC_LOAD_STROBE,
    output logic [7:0]       PORT_A_DIRECTION,
    output logic [7:0]       PORT_B_DIRECTION,
    output logic [1:0]       OSC_MODE,
    output logic             CODE_PROTECTED
);
    import rcc_pkg::*;

    localparam int FILT_CYC = (`RCC_FILT_CYC < 1) ? 1 : `RCC_FILT_CYC;

    // config cells are nonvolatile: erased at start, kept through resets
    rcc_cfg_s     cfg = rcc_cfg_s'(`RCC_CFG_ERASED);               // [RULE1]
    logic [7:0]   status;
    logic [7:0]   intctl;
    logic [7:0]   ctrl;
    logic [12:0]  pc_q;
    rcc_kind_e    kind;
    rcc_aphase_s  ap;
    logic         ap_valid;
    logic         por_done;
    logic         pin_n;
    logic [3:0]   filt_cnt;
    logic [31:0]  power_up_delay_timer_cnt;
    logic [10:0]  ost_cnt;
    logic         wdt_req;
    logic [7:0]   wdt_cnt;
    logic         hold_power_up_delay_timer;
    logic         hold_ost;
    logic         pin_fell;

    // code protected unless the field is all erased
    function automatic logic cp_on(input rcc_cfg_s c);
        cp_on = (c.code_protect != 10'h3ff);
    endfunction : cp_on

    function automatic logic is_crystal(input rcc_cfg_s c);
        is_crystal = ({c.osc_select_hi, c.osc_select_lo} != RCC_OSC_RC);
    endfunction : is_crystal

    assign OSC_MODE       = {cfg.osc_select_hi, cfg.osc_select_lo}; // [RULE5]
    assign CODE_PROTECTED = cp_on(cfg);                             // [RULE24]
    assign RESET_KIND     = kind;
    assign HREADYOUT      = 1'b1;
    assign HRESP          = 1'b0;
    assign CORE_RESET     = hold_power_up_delay_timer | hold_ost | ~pin_n;

    // reset pin noise filter: level must persist FILT_CYC cycles
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            // idle level of the pin, so release gives no false edge
            pin_n    <= 1'b1;
            filt_cnt <= 4'h0;
        end else if (EXTERNAL_RESET_PIN_N == pin_n) begin
            filt_cnt <= 4'h0;
        end else if (filt_cnt >= 4'(FILT_CYC - 1)) begin
            pin_n    <= EXTERNAL_RESET_PIN_N;                       // [RULE11]
            filt_cnt <= 4'h0;
        end else begin
            filt_cnt <= filt_cnt + 4'h1;
        end
    end
    assign pin_fell = pin_n & ~EXTERNAL_RESET_PIN_N
                    & (filt_cnt >= 4'(FILT_CYC - 1));

    // configuration word; not reset, or the power-up delay could never
    // be enabled at power-on; only prog mode writes it
    always_ff @(posedge CLK) begin
        if (RST_N && ap_valid && ap.hwrite && PROG_MODE
            && ap.haddr == `RCC_OFF_CFG) begin
            cfg <= rcc_cfg_s'(HWDATA[13:0]);                        // [RULE2]
        end
    end

    // watchdog on own rc tick; only the config bit stops it
    always_ff @(posedge CLK) begin
        if (!RST_N || !cfg.watchdog_enable) begin                  // [RULE4]
            wdt_cnt <= 8'h00;
            wdt_req <= 1'b0;
        end else if (ap_valid && ap.hwrite && ap.haddr == `RCC_OFF_CTRL
                     && HWDATA[0]) begin
            wdt_cnt <= 8'h00;
            wdt_req <= 1'b0;
        end else if (WDT_RC_TICK) begin                            // [RULE6]
            wdt_cnt <= wdt_cnt + 8'h01;
            wdt_req <= (wdt_cnt == ctrl);
        end else begin
            wdt_req <= 1'b0;
        end
    end

    // power-up delay, only after power-on
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            power_up_delay_timer_cnt  <= 32'h0;
            hold_power_up_delay_timer <= 1'b1;
            por_done  <= 1'b0;
        end else if (!por_done) begin
            por_done  <= 1'b1;
            hold_power_up_delay_timer <= ~cfg.power_up_delay_enable_n;              // [RULE3]
        end else if (hold_power_up_delay_timer) begin
            if (power_up_delay_timer_cnt >= 32'(POWER_UP_DELAY_TIMER_CYC - 1))
                hold_power_up_delay_timer <= 1'b0;                                  // [RULE7]
            power_up_delay_timer_cnt <= power_up_delay_timer_cnt + 32'h1;
        end
    end

    // oscillator start-up timer: 1024 osc ticks, crystal modes only
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            hold_ost <= 1'b0;
            ost_cnt  <= 11'h0;
        end else if ((!por_done || (SLEEPING && (wdt_req || IRQ_WAKE)))
                     && is_crystal(cfg)) begin                      // [RULE23]
            hold_ost <= 1'b1;
            ost_cnt  <= 11'h0;
        end else if (hold_ost && !hold_power_up_delay_timer && OSC_TICK) begin     // [RULE22]
            if (ost_cnt == 11'(`RCC_OST_OSC_CYC - 1))
                hold_ost <= 1'b0;                                   // [RULE8]
            ost_cnt <= ost_cnt + 11'h1;
        end
    end

    // classify reset and apply register reset states
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            kind             <= RCC_K_POR;                          // [RULE10]
            status           <= `RCC_STATUS_POR;                    // [RULE16]
            intctl           <= `RCC_INTCTL_POR;
            pc_q             <= `RCC_PC_ZERO;
            PC_LOAD          <= `RCC_PC_ZERO;
            PC_LOAD_STROBE   <= 1'b0;
            PORT_A_DIRECTION <= `RCC_DIR_ALL_IN;
            PORT_B_DIRECTION <= `RCC_DIR_ALL_IN;
            ctrl             <= 8'hff;
        end else begin
            PC_LOAD_STROBE <= 1'b0;
            if (pin_fell || (wdt_req && !SLEEPING)) begin
                // true resets: pc 0, directions input, intctl keeps bit 0
                kind   <= pin_fell ? (SLEEPING ? RCC_K_PIN_SLEEP
                                               : RCC_K_PIN_RUN)
                                   : RCC_K_WDT_RUN;                 // [RULE10]
                PC_LOAD          <= `RCC_PC_ZERO;                   // [RULE14]
                PC_LOAD_STROBE   <= 1'b1;
                PORT_A_DIRECTION <= `RCC_DIR_ALL_IN;                // [RULE19]
                PORT_B_DIRECTION <= `RCC_DIR_ALL_IN;
                intctl <= {7'h00, intctl[0]};                       // [RULE18]
                ctrl   <= 8'hff;                                    // [RULE13]
                if (pin_fell && !SLEEPING)
                    status[7:5] <= 3'b000;                          // [RULE16]
                else if (pin_fell)
                    status[7:3] <= 5'b00010;                        // [RULE17]
                else
                    status[7:3] <= 5'b00001;                        // [RULE17]
            end else if (SLEEPING && (wdt_req || IRQ_WAKE)) begin   // [RULE9]
                // wake-up: registers kept, only wake flags set
                kind   <= wdt_req ? RCC_K_WDT_WAKE : RCC_K_IRQ_WAKE;
                status[`RCC_TO_BIT:`RCC_PD_BIT] <=
                    wdt_req ? 2'b00 : 2'b10;                        // [RULE17]
                intctl <= intctl | WAKE_FLAGS;                      // [RULE18]
                PC_LOAD_STROBE <= 1'b1;
                if (!wdt_req && intctl[`RCC_GIE_BIT])
                    PC_LOAD <= `RCC_PC_VECTOR;                      // [RULE15]
                else
                    PC_LOAD <= PC_IN + 13'h1;                       // [RULE14]
            end else if (ap_valid && ap.hwrite) begin
                // software writes; unlisted registers untouched  [RULE12]
                unique case (ap.haddr)
                    `RCC_OFF_STATUS: status[2:0] <= HWDATA[2:0];
                    `RCC_OFF_CTRL:   ctrl <= {HWDATA[7:1], 1'b0} | 8'h01;
                    `RCC_OFF_INTCTL: intctl <= HWDATA[7:0];
                    `RCC_OFF_DIR:    begin
                        PORT_A_DIRECTION <= HWDATA[7:0];
                        PORT_B_DIRECTION <= HWDATA[15:8];
                    end
                    default: ;
                endcase
            end
            pc_q <= PC_IN;
        end
    end

    // ahb-lite address phase capture; zero wait states
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ap_valid <= 1'b0;
            ap       <= '0;
        end else if (HREADY) begin
            ap_valid <= HSEL & HTRANS[1];
            ap       <= '{htrans1: HTRANS[1], hwrite: HWRITE,
                          haddr: {HADDR[31:2], 2'b00}};
        end
    end

    // read mux; unmapped, and config outside prog mode, read zero
    always_comb begin
        HRDATA = 32'h0;
        if (ap_valid && !ap.hwrite) begin
            unique case (ap.haddr)
                `RCC_OFF_STATUS: HRDATA = {24'h0, status};
                `RCC_OFF_CFG:    if (PROG_MODE)
                                     HRDATA = {18'h0, cfg};         // [RULE2]
                `RCC_OFF_CTRL:   HRDATA = {24'h0, ctrl};
                `RCC_OFF_EVENT:  HRDATA = {30'h0, hold_ost, hold_power_up_delay_timer};
                `RCC_OFF_CAUSE:  HRDATA = {29'h0, kind};
                `RCC_OFF_PC:     HRDATA = {19'h0, pc_q};
                `RCC_OFF_INTCTL: HRDATA = {24'h0, intctl};
                `RCC_OFF_DIR:    HRDATA = {16'h0, PORT_B_DIRECTION,
                                           PORT_A_DIRECTION};
                default:         HRDATA = 32'h0;
            endcase
        end
    end

    // the start-up timer only releases after the power-up delay
    ost_after_power_up_delay_timer_a: assert property (@(posedge CLK) disable iff (!RST_N)
        $fell(hold_ost) |-> !hold_power_up_delay_timer) // [RULE22]
        else $error("start-up timer released during power-up delay");
    // rc mode never starts the start-up timer
    ost_rc_mode_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (OSC_MODE == RCC_OSC_RC && !hold_ost) |=> !hold_ost) // [RULE23]
        else $error("start-up timer ran in rc mode");
    // a true reset leaves pc at zero and port b as inputs
    true_reset_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (pin_fell || (wdt_req && !SLEEPING)) |=>
        (PC_LOAD == 13'h0 && PORT_B_DIRECTION == 8'hff
         && PC_LOAD_STROBE)) // [RULE14]
        else $error("true reset did not load pc zero");
    // watchdog wake clears both cause flags
    wdt_wake_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (SLEEPING && wdt_req && !pin_fell) |=>
        status[4:3] == 2'b00 && kind == RCC_K_WDT_WAKE) // [RULE17]
        else $error("watchdog wake flags wrong");
    // irq wake with global enable vectors
    irq_vector_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (SLEEPING && IRQ_WAKE && !wdt_req && !pin_fell
         && intctl[7]) |=> PC_LOAD == 13'h0004) // [RULE15]
        else $error("irq wake did not vector");
    // disabled watchdog never requests
    wdt_off_a: assert property (@(posedge CLK) disable iff (!RST_N)
        !cfg.watchdog_enable |=> !wdt_req) // [RULE6]
        else $error("disabled watchdog fired");
    // a one-cycle pin glitch does not change the filtered level
    pin_filter_a: assert property (@(posedge CLK) disable iff (!RST_N)
        ($stable(pin_n) && EXTERNAL_RESET_PIN_N != pin_n && filt_cnt == 0)
        |=> $stable(pin_n)) // [RULE11]
        else $error("reset pin glitch passed filter");
    // pin reset while running clears the top status bits
    pin_status_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (pin_fell && !SLEEPING) |=> status[7:5] == 3'b000
        && kind == RCC_K_PIN_RUN) // [RULE16]
        else $error("pin reset status wrong");
    // power-on arms the delay timer from the config bit
    power_up_delay_timer_arm_a: assert property (@(posedge CLK) disable iff (!RST_N)
        !por_done |=> hold_power_up_delay_timer == !cfg.power_up_delay_enable_n) // [RULE3]
        else $error("power-up delay not armed from config");
    // the start-up timer lets go right after its last oscillator tick
    ost_release_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (hold_ost && !hold_power_up_delay_timer && OSC_TICK && por_done && !SLEEPING
         && ost_cnt == 11'h3ff) |=> !hold_ost) // [RULE22]
        else $error("start-up timer overran its count");
    // watchdog reset while running marks the timeout cause
    wdt_run_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (wdt_req && !SLEEPING && !pin_fell) |=>
        status[4:3] == 2'b01 && kind == RCC_K_WDT_RUN) // [RULE17]
        else $error("watchdog reset cause flags wrong");
    // a wake-up leaves the port directions alone
    wake_dir_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (SLEEPING && (wdt_req || IRQ_WAKE) && !pin_fell) |=>
        $stable(PORT_A_DIRECTION) && $stable(PORT_B_DIRECTION)) // [RULE13]
        else $error("wake-up changed port directions");
    // power-on leaves every pin an input
    por_dir_a: assert property (@(posedge CLK) disable iff (!RST_N)
        !por_done |-> PORT_A_DIRECTION == 8'hff
        && PORT_B_DIRECTION == 8'hff) // [RULE19]
        else $error("power-on left a pin as output");
endmodule : rcc_top

// >>> verification/rcc_far_model.sv
// far-side model: oscillator and watchdog ticks, external reset source
module rcc_far_model (
    // clock and command
    input  wire logic clk,
    input  wire logic pin_assert,
    // device pins
    output logic      osc_tick,
    output logic      wdt_rc_tick,
    output logic      external_reset_pin_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] div = 2'h0;
    always_ff @(posedge clk) begin
        div <= div + 2'h1;
    end
    // external clock on the oscillator input in place of a crystal
    assign osc_tick             = div[0];
    assign wdt_rc_tick          = (div == 2'h3);
    // pulled up whenever the source is idle
    assign external_reset_pin_n = !pin_assert;
endmodule : rcc_far_model

// >>> verification/tb_rcc_top.sv
// self-checking bench for the reset and configuration controller
`include "rcc_defs.svh"
module tb_rcc_top;
    timeunit 1ns;
    timeprecision 1ps;
    import rcc_pkg::*;
    logic        CLK = 1'b0, RST_N = 1'b0, HSEL = 1'b0, HWRITE = 1'b0;
    logic        PROG_MODE = 1'b0, SLEEPING = 1'b0, IRQ_WAKE = 1'b0;
    logic        pin_assert = 1'b0, watch = 1'b0;
    logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, rd;
    logic [1:0]  HTRANS = 2'h0;
    logic [2:0]  HSIZE = 3'h2;
    logic [7:0]  WAKE_FLAGS = 8'h0;
    logic [12:0] PC_IN = 13'h0;
    wire  [31:0] HRDATA;
    wire         HREADYOUT, HRESP, OSC_TICK, WDT_RC_TICK, PIN_N;
    wire         CORE_RESET, PC_LOAD_STROBE, CODE_PROTECTED;
    wire  [2:0]  RESET_KIND;
    wire  [12:0] PC_LOAD;
    wire  [7:0]  PORT_A_DIRECTION, PORT_B_DIRECTION;
    wire  [1:0]  OSC_MODE;
    logic [15:0] expq[$];
    int          bad_count = 0, tests_run = 0, cyc = 0, seed = 32'hd481;

    rcc_top #(.POWER_UP_DELAY_TIMER_CYC(20)) rcc_top_i (
        .CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
        .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
        .HRESP(HRESP), .EXTERNAL_RESET_PIN_N(PIN_N), .OSC_TICK(OSC_TICK),
        .WDT_RC_TICK(WDT_RC_TICK), .PROG_MODE(PROG_MODE),
        .SLEEPING(SLEEPING), .IRQ_WAKE(IRQ_WAKE), .WAKE_FLAGS(WAKE_FLAGS),
        .PC_IN(PC_IN), .CORE_RESET(CORE_RESET), .RESET_KIND(RESET_KIND),
        .PC_LOAD(PC_LOAD), .PC_LOAD_STROBE(PC_LOAD_STROBE),
        .PORT_A_DIRECTION(PORT_A_DIRECTION),
        .PORT_B_DIRECTION(PORT_B_DIRECTION), .OSC_MODE(OSC_MODE),
        .CODE_PROTECTED(CODE_PROTECTED));
    rcc_far_model rcc_far_model_i (
        .clk(CLK), .pin_assert(pin_assert), .osc_tick(OSC_TICK),
        .wdt_rc_tick(WDT_RC_TICK), .external_reset_pin_n(PIN_N));

    initial begin
        forever #2 CLK = ~CLK;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                     exp);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test

    // one single word transfer; address phase held until hready
    task automatic bus(input logic wr, input logic [31:0] a,
                       input logic [31:0] wd);
        @(posedge CLK);
        HSEL   <= 1'b1;
        HTRANS <= 2'h2;
        HADDR  <= a;
        HWRITE <= wr;
        @(posedge CLK);
        while (HREADYOUT !== 1'b1) @(posedge CLK);
        HSEL   <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= wd;
        @(posedge CLK);
        while (HREADYOUT !== 1'b1) @(posedge CLK);
        rd = HRDATA;
        check({31'h0, HRESP}, 32'h0);
    endtask : bus

    task automatic rdchk(input logic [31:0] a, input logic [31:0] m,
                         input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check(rd & m, e);
    endtask : rdchk

    task automatic wait_strobe();
        repeat (3000) begin
            @(posedge CLK);
            if (PC_LOAD_STROBE === 1'b1) return;
        end
        check(32'h0, 32'h1);
    endtask : wait_strobe

    task automatic irq_wake(input logic [15:0] e);
        SLEEPING <= 1'b1;
        expq.push_back(e);
        @(posedge CLK);
        IRQ_WAKE   <= 1'b1;
        WAKE_FLAGS <= 8'($random(seed)) & 8'h07;
        @(posedge CLK);
        IRQ_WAKE   <= 1'b0;
    endtask : irq_wake

    task automatic pin(input int n);
        pin_assert <= 1'b1;
        repeat (n) @(posedge CLK);
        if (n > 3) check({31'h0, CORE_RESET}, 32'h1);
        pin_assert <= 1'b0;
    endtask : pin

    // every strobe must match the oldest noted reset
    always @(posedge CLK) begin
        if (watch && PC_LOAD_STROBE === 1'b1) begin
            if (expq.size() == 0) begin
                check(32'h0, 32'h1);
            end else begin
                check({16'h0, RESET_KIND, PC_LOAD},
                      {16'h0, expq.pop_front()});
            end
        end
    end

    always @(posedge CLK) begin
        cyc++;
        if (cyc == 12000) begin
            bad_count++;
            finish_test();
        end
    end

    initial begin
        repeat (6) @(posedge CLK);
        RST_N     <= 1'b1;
        PROG_MODE <= 1'b1;
        PC_IN     <= 13'($random(seed));
        @(posedge CLK);
        check({29'h0, RESET_KIND}, 32'h1);
        // watchdog off first so it cannot fire during other tests
        bus(1'b1, `RCC_OFF_CFG, 32'h3ffb);
        check({31'h0, CORE_RESET}, 32'h0);
        check({16'h0, PORT_B_DIRECTION, PORT_A_DIRECTION},
              32'hffff);
        rdchk(`RCC_OFF_STATUS, 32'hf8, 32'h18);
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, `RCC_OFF_CFG, 32'h3ff8 | m);
            rdchk(`RCC_OFF_CFG, 32'hffff_ffff, 32'h3ff8 | m);
            check({30'h0, OSC_MODE}, 32'(m));
        end
        bus(1'b1, `RCC_OFF_CFG, 32'h000b);
        rdchk(`RCC_OFF_CFG, 32'hffff_ffff, 32'h000b);
        check({31'h0, CODE_PROTECTED}, 32'h1);
        bus(1'b1, `RCC_OFF_CFG, 32'h3ffb);
        PROG_MODE <= 1'b0;
        bus(1'b1, `RCC_OFF_CFG, 32'h0);
        rdchk(`RCC_OFF_CFG, 32'hffff_ffff, 32'h0);
        PROG_MODE <= 1'b1;
        rdchk(`RCC_OFF_CFG, 32'hffff_ffff, 32'h3ffb);
        check({31'h0, CODE_PROTECTED}, 32'h0);
        $display("config tests done");
        // standard crystal below 3.5 MHz, high speed above
        bus(1'b1, `RCC_OFF_CFG, 32'h3ff9);
        watch <= 1'b1;
        irq_wake({RCC_K_IRQ_WAKE, 13'(PC_IN + 13'h1)});
        repeat (1900) @(posedge CLK);
        check({31'h0, CORE_RESET}, 32'h1);
        repeat (300) @(posedge CLK);
        check({31'h0, CORE_RESET}, 32'h0);
        SLEEPING <= 1'b0;
        bus(1'b1, `RCC_OFF_CFG, 32'h3ffb);
        bus(1'b1, `RCC_OFF_INTCTL, 32'h80);
        irq_wake({RCC_K_IRQ_WAKE, `RCC_PC_VECTOR});
        wait_strobe();
        SLEEPING <= 1'b0;
        rdchk(`RCC_OFF_INTCTL, 32'hff,
              {24'h0, 8'h80 | WAKE_FLAGS});
        rdchk(`RCC_OFF_STATUS, 32'h18, 32'h10);
        $display("wake tests done");
        pin(1);
        repeat (10) @(posedge CLK);
        check(32'(expq.size()), 32'h0);
        SLEEPING <= 1'b1;
        expq.push_back({RCC_K_PIN_SLEEP, `RCC_PC_ZERO});
        pin(6);
        SLEEPING <= 1'b0;
        rdchk(`RCC_OFF_STATUS, 32'hf8, 32'h10);
        rdchk(`RCC_OFF_INTCTL, 32'hfe, 32'h0);
        bus(1'b1, `RCC_OFF_DIR, 32'ha55a);
        expq.push_back({RCC_K_PIN_RUN, `RCC_PC_ZERO});
        pin(6);
        rdchk(`RCC_OFF_DIR, 32'hffff, 32'hffff);
        rdchk(`RCC_OFF_STATUS, 32'he0, 32'h0);
        $display("pin tests done");
        expq.push_back({RCC_K_WDT_RUN, `RCC_PC_ZERO});
        bus(1'b1, `RCC_OFF_CFG, 32'h3fff);
        bus(1'b1, `RCC_OFF_CTRL, 32'h28);
        wait_strobe();
        bus(1'b1, `RCC_OFF_CTRL, 32'h28);
        rdchk(`RCC_OFF_STATUS, 32'h18, 32'h08);
        bus(1'b1, `RCC_OFF_DIR, 32'ha55a);
        SLEEPING <= 1'b1;
        expq.push_back({RCC_K_WDT_WAKE, 13'(PC_IN + 13'h1)});
        wait_strobe();
        SLEEPING <= 1'b0;
        bus(1'b1, `RCC_OFF_CFG, 32'h3ffb);
        rdchk(`RCC_OFF_STATUS, 32'h18, 32'h0);
        rdchk(`RCC_OFF_DIR, 32'hffff, 32'ha55a);
        repeat (600) @(posedge CLK);
        check(32'(expq.size()), 32'h0);
        $display("watchdog tests done");
        // second power-on: delay enabled, crystal mode kept in config
        bus(1'b1, `RCC_OFF_CFG, 32'h3ff1);
        RST_N <= 1'b0;
        repeat (2) @(posedge CLK);
        RST_N <= 1'b1;
        repeat (2) @(posedge CLK);
        check({29'h0, RESET_KIND}, 32'h1);
        rdchk(`RCC_OFF_EVENT, 32'h3, 32'h3);
        rdchk(`RCC_OFF_CFG, 32'hffff_ffff, 32'h3ff1);
        repeat (30) @(posedge CLK);
        rdchk(`RCC_OFF_EVENT, 32'h3, 32'h2);
        check({31'h0, CORE_RESET}, 32'h1);
        repeat (2100) @(posedge CLK);
        check({31'h0, CORE_RESET}, 32'h0);
        $display("power-up tests done");
        finish_test();
    end
endmodule : tb_rcc_top
